// *** adcc_pkg.sv ***
// Shared constants, types and helpers of the calibration coefficient block
package adcc_pkg;

    localparam int COEF_WIDTH = 24;
    localparam int GAIN_FRAC_BITS = 23;
    localparam int CONV16_FRAC_BITS = 8;

    // Register port addresses
    localparam logic [3:0] ADDR_OFFSET_COEF_HIGH = 4'h0;
    localparam logic [3:0] ADDR_OFFSET_COEF_MID = 4'h1;
    localparam logic [3:0] ADDR_OFFSET_COEF_LOW = 4'h2;
    localparam logic [3:0] ADDR_GAIN_COEF_HIGH = 4'h3;
    localparam logic [3:0] ADDR_GAIN_COEF_MID = 4'h4;
    localparam logic [3:0] ADDR_GAIN_COEF_LOW = 4'h5;
    localparam logic [3:0] ADDR_SYSTEM_MODE = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;

    // Status register bit positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_COMPLETE_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;
    localparam int STAT_ERROR_BIT = 3;

    // System mode field codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_SYS_OFFSET = 3'h4;
    localparam logic [2:0] MODE_SYS_GAIN = 3'h5;

    // Reset values, coefficient limits and gain divider constants
    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [23:0] GAIN_RESET = 24'h800000;
    localparam logic [23:0] OFFSET_POS_FULL = 24'h7FFFFF;
    localparam logic [23:0] OFFSET_NEG_FULL = 24'h800000;
    localparam logic [23:0] GAIN_MIN = 24'h000000;
    localparam logic [23:0] GAIN_MAX = 24'hFFFFFF;
    localparam logic [23:0] GAIN_TARGET = 24'h7FFFFF;
    localparam logic [5:0] DIV_STEPS = 6'h2E;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } adcc_sample_type;

    typedef struct packed {
        logic error;
        logic irq;
        logic complete;
        logic busy;
    } adcc_status_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_DIVIDE = 2'h3,
        ST_FINISH = 2'h2
    } adcc_state_type;

    // Clamp a wide signed value into a 24-bit two's complement code
    function automatic logic [23:0] adcc_sat(input logic signed [48:0] v);
        if (v > 49'sh7FFFFF)
            return OFFSET_POS_FULL;
        else if (v < -49'sh800000)
            return OFFSET_NEG_FULL;
        else
            return v[23:0];
    endfunction : adcc_sat

endpackage : adcc_pkg

// *** adcc_corrector.sv ***
// Offset subtraction and gain scaling of each conversion result
`timescale 1ns/1ps
module adcc_corrector
    import adcc_pkg::*;
#(
    parameter int FRAC_BITS = GAIN_FRAC_BITS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Coefficients
    input wire logic [23:0] offset_coef,
    input wire logic [23:0] gain_coef,
    // Samples
    input wire adcc_sample_type sample_in,
    output adcc_sample_type sample_out
);

    adcc_sample_type stage;
    logic signed [48:0] diff_wide;
    logic signed [48:0] prod_wide;

    always_comb
    begin
        diff_wide = 49'(signed'(sample_in.data)) - 49'(signed'(offset_coef));
    end

    always_comb
    begin
        prod_wide = 49'(signed'(stage.data) * signed'({1'b0, gain_coef})) >>> FRAC_BITS;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage <= '0;
            sample_out <= '0;
        end
        else
        begin
            stage.valid <= sample_in.valid;
            stage.data <= adcc_sat(diff_wide);
            sample_out.valid <= stage.valid;
            sample_out.data <= adcc_sat(prod_wide);
        end
    end

    property p_result_latency;
        @(posedge clk) disable iff (reset)
        sample_in.valid |-> ##2 sample_out.valid;
    endproperty
    a_result_latency: assert property (p_result_latency)
        else $error("corrected result did not follow its sample after two cycles");

    property p_unity_passthrough;
        @(posedge clk) disable iff (reset)
        (sample_in.valid && offset_coef == OFFSET_RESET && gain_coef == GAIN_RESET) ##1
            (offset_coef == OFFSET_RESET && gain_coef == GAIN_RESET)
            |=> sample_out.data == $past(sample_in.data, 2);
    endproperty
    a_unity_passthrough: assert property (p_unity_passthrough)
        else $error("zero offset and unity gain altered the sample");

endmodule : adcc_corrector

// *** adcc_cal_ctrl.sv ***
// System calibration control and coefficient registers of the converter
`timescale 1ns/1ps
//
// Contract
// - Only system offset and system gain calibration, both measuring the external inputs.
// - Offset and gain coefficients are separate 24-bit values.
// - Software can read and write every coefficient byte.
// - Offset is 24-bit two's complement in high, middle, low bytes.
// - Offset calibration ending at either full-scale code flags an error; the 16-bit variant flags only the negative one (0x7FFF aligns to 7FFF00).
// - Offset bit weights: 24-bit variant LSB units, 16-bit variant eight fraction bits.
// - Gain is unsigned 24-bit fixed point in high, middle, low bytes.
// - Gain bit 23 weighs one, each lower bit half of the one above.
// - Gain ranges from zero to two minus two to the minus 23rd.
// - Gain calibration ending at zero or maximum flags an error.
// - Each result has offset subtracted, then is multiplied by gain.
// - Busy while calibrating; at end mode idles, complete and interrupt set, coefficients written.
// - Clearing the interrupt flag also clears the complete flag.
module adcc_cal_ctrl
    import adcc_pkg::*;
#(
    parameter bit VARIANT_16BIT = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Raw conversions from the filter
    input wire adcc_sample_type raw_sample,
    // Corrected conversions
    output adcc_sample_type result,
    // Status
    output adcc_status_type status
);

    adcc_state_type state;
    logic [2:0] system_mode_field;
    logic [23:0] offset_coef;
    logic [23:0] gain_coef;
    logic [23:0] cal_value;
    logic cal_fail;
    logic [47:0] div_rem;
    logic [46:0] div_quot;
    logic [24:0] div_den;
    logic [5:0] div_count;
    logic [47:0] next_rem_trial;
    logic signed [24:0] gain_delta;
    logic [23:0] aligned_data;
    adcc_sample_type aligned_sample;
    logic start_cal;
    logic finish;
    logic wr_status;

    localparam logic [46:0] DIV_NUM = {GAIN_TARGET, 23'h000000};

    // 16-bit codes carry eight fraction bits below
    always_comb
    begin
        aligned_data = VARIANT_16BIT ? {raw_sample.data[15:0], 8'h00} : raw_sample.data;
        aligned_sample.valid = raw_sample.valid;
        aligned_sample.data = aligned_data;
        gain_delta = 25'(signed'(aligned_data)) - 25'(signed'(offset_coef));
        next_rem_trial = {div_rem[46:0], DIV_NUM[div_count]};
    end

    // only the two system calibrations start
    assign start_cal = reg_write && reg_addr == ADDR_SYSTEM_MODE && state == ST_IDLE
        && (reg_wdata[2:0] == MODE_SYS_OFFSET || reg_wdata[2:0] == MODE_SYS_GAIN);
    assign finish = state == ST_FINISH;
    assign wr_status = reg_write && reg_addr == ADDR_STATUS;

    // Calibration sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (start_cal)
                        state <= ST_WAIT;
                ST_WAIT:
                    if (raw_sample.valid)
                        state <= (system_mode_field == MODE_SYS_GAIN && gain_delta > 25'sh0) ? ST_DIVIDE : ST_FINISH;
                ST_DIVIDE:
                    if (div_count == 6'h00)
                        state <= ST_FINISH;
                ST_FINISH:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Gain measurement divider, one quotient bit per cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            div_rem <= '0;
            div_quot <= '0;
            div_den <= '0;
            div_count <= '0;
        end
        else if (state == ST_WAIT)
        begin
            div_rem <= '0;
            div_quot <= '0;
            div_den <= gain_delta;
            div_count <= DIV_STEPS;
        end
        else if (state == ST_DIVIDE)
        begin
            div_count <= div_count - 6'h01;
            if (next_rem_trial >= {23'h000000, div_den})
            begin
                div_rem <= next_rem_trial - {23'h000000, div_den};
                div_quot <= {div_quot[45:0], 1'b1};
            end
            else
            begin
                div_rem <= next_rem_trial;
                div_quot <= {div_quot[45:0], 1'b0};
            end
        end
    end

    // Calibration outcome
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cal_value <= '0;
            cal_fail <= 1'b0;
        end
        else if (state == ST_WAIT && raw_sample.valid)
        begin
            if (system_mode_field == MODE_SYS_OFFSET)
            begin
                cal_value <= aligned_data;
                cal_fail <= aligned_data == OFFSET_POS_FULL || aligned_data == OFFSET_NEG_FULL;
            end
            else
            begin
                // Non-positive span cannot give a slope
                cal_value <= GAIN_MAX;
                cal_fail <= 1'b1;
            end
        end
        else if (state == ST_DIVIDE && div_count == 6'h00)
        begin
            if ({div_quot[45:0], next_rem_trial >= {23'h000000, div_den}} >= {23'h000000, GAIN_MAX})
            begin
                cal_value <= GAIN_MAX;
                cal_fail <= 1'b1;
            end
            else
            begin
                cal_value <= {div_quot[22:0], next_rem_trial >= {23'h000000, div_den}};
                cal_fail <= {div_quot[22:0], next_rem_trial >= {23'h000000, div_den}} == GAIN_MIN;
            end
        end
    end

    // Mode field returns to idle when done
    always_ff @(posedge clk)
    begin
        if (reset)
            system_mode_field <= MODE_IDLE;
        else if (start_cal)
            system_mode_field <= reg_wdata[2:0];
        else if (finish)
            system_mode_field <= MODE_IDLE;
    end

    // coefficient bytes; calibration wins a same-cycle write
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            offset_coef <= OFFSET_RESET;
            gain_coef <= GAIN_RESET;
        end
        else if (finish)
        begin
            if (system_mode_field == MODE_SYS_OFFSET)
                offset_coef <= cal_value;
            else
                gain_coef <= cal_value;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                ADDR_OFFSET_COEF_HIGH: offset_coef[23:16] <= reg_wdata;
                ADDR_OFFSET_COEF_MID: offset_coef[15:8] <= reg_wdata;
                ADDR_OFFSET_COEF_LOW: offset_coef[7:0] <= reg_wdata;
                ADDR_GAIN_COEF_HIGH: gain_coef[23:16] <= reg_wdata;
                ADDR_GAIN_COEF_MID: gain_coef[15:8] <= reg_wdata;
                ADDR_GAIN_COEF_LOW: gain_coef[7:0] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Status flags; a completing calibration beats a clearing write
    always_ff @(posedge clk)
    begin
        if (reset)
            status <= '0;
        else
        begin
            status.busy <= start_cal || (status.busy && !finish);
            if (finish)
            begin
                status.complete <= 1'b1;
                status.irq <= 1'b1;
            end
            else if (wr_status && !reg_wdata[STAT_IRQ_BIT])
            begin
                status.complete <= 1'b0;
                status.irq <= 1'b0;
            end
            if (finish && cal_fail)
                status.error <= 1'b1;
            else if (wr_status && !reg_wdata[STAT_ERROR_BIT])
                status.error <= 1'b0;
        end
    end

    // Registered read data, one cycle after the address
    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else
        begin
            unique case (reg_addr)
                ADDR_OFFSET_COEF_HIGH: reg_rdata <= offset_coef[23:16];
                ADDR_OFFSET_COEF_MID: reg_rdata <= offset_coef[15:8];
                ADDR_OFFSET_COEF_LOW: reg_rdata <= offset_coef[7:0];
                ADDR_GAIN_COEF_HIGH: reg_rdata <= gain_coef[23:16];
                ADDR_GAIN_COEF_MID: reg_rdata <= gain_coef[15:8];
                ADDR_GAIN_COEF_LOW: reg_rdata <= gain_coef[7:0];
                ADDR_SYSTEM_MODE: reg_rdata <= {5'h00, system_mode_field};
                ADDR_STATUS: reg_rdata <= {4'h0, status};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    adcc_corrector #(
        .FRAC_BITS(GAIN_FRAC_BITS)
    ) u_corrector (
        .clk(clk),
        .reset(reset),
        .offset_coef(offset_coef),
        .gain_coef(gain_coef),
        .sample_in(aligned_sample),
        .sample_out(result)
    );

    property p_bad_mode_ignored;
        @(posedge clk) disable iff (reset)
        (state == ST_IDLE && reg_write && reg_addr == ADDR_SYSTEM_MODE
            && reg_wdata[2:0] != MODE_SYS_OFFSET && reg_wdata[2:0] != MODE_SYS_GAIN)
            |=> state == ST_IDLE && !status.busy;
    endproperty
    a_bad_mode_ignored: assert property (p_bad_mode_ignored)
        else $error("a non-calibration mode code started a calibration");

    property p_offset_byte_write;
        @(posedge clk) disable iff (reset)
        (reg_write && reg_addr == ADDR_OFFSET_COEF_HIGH && !finish)
            |=> offset_coef[23:16] == $past(reg_wdata);
    endproperty
    a_offset_byte_write: assert property (p_offset_byte_write)
        else $error("offset high byte write not stored");

    property p_gain_byte_read;
        @(posedge clk) disable iff (reset)
        (reg_addr == ADDR_GAIN_COEF_MID) |=> reg_rdata == $past(gain_coef[15:8]);
    endproperty
    a_gain_byte_read: assert property (p_gain_byte_read)
        else $error("gain middle byte read returned wrong value");

    property p_offset_rail_error;
        @(posedge clk) disable iff (reset)
        (state == ST_WAIT && raw_sample.valid && system_mode_field == MODE_SYS_OFFSET
            && (aligned_data == OFFSET_POS_FULL || aligned_data == OFFSET_NEG_FULL))
            |-> ##2 status.error && offset_coef == $past(aligned_data, 2);
    endproperty
    a_offset_rail_error: assert property (p_offset_rail_error)
        else $error("offset calibration at full scale did not flag an error");

    property p_gain_rail_error;
        @(posedge clk) disable iff (reset)
        (finish && system_mode_field == MODE_SYS_GAIN && (cal_value == GAIN_MIN || cal_value == GAIN_MAX))
            |=> status.error;
    endproperty
    a_gain_rail_error: assert property (p_gain_rail_error)
        else $error("gain calibration at a rail did not flag an error");

    property p_completion;
        @(posedge clk) disable iff (reset)
        finish |=> !status.busy && status.complete && status.irq
            && system_mode_field == MODE_IDLE && state == ST_IDLE;
    endproperty
    a_completion: assert property (p_completion)
        else $error("calibration completion flags wrong");

    property p_busy_span;
        @(posedge clk) disable iff (reset)
        start_cal |=> status.busy throughout (state != ST_IDLE) [*2];
    endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("busy flag dropped during calibration");

    property p_clear_complete;
        @(posedge clk) disable iff (reset)
        (wr_status && !reg_wdata[STAT_IRQ_BIT] && !finish) |=> !status.complete && !status.irq;
    endproperty
    a_clear_complete: assert property (p_clear_complete)
        else $error("clearing the interrupt left complete set");

    // Measured from the first divide step; the wait for a conversion has no bound of its own
    property p_divide_bounded;
        @(posedge clk) disable iff (reset)
        (state == ST_DIVIDE && div_count == DIV_STEPS) |-> ##[1:60] state == ST_IDLE;
    endproperty
    a_divide_bounded: assert property (p_divide_bounded)
        else $error("calibration did not finish in time");

endmodule : adcc_cal_ctrl

// *** adcc_cal_source.sv ***
// Model of the calibration voltage and converter feeding raw conversions
`timescale 1ns/1ps
module adcc_cal_source
    import adcc_pkg::*;
#(
    parameter logic [23:0] ZERO_CODE = 24'h000020,
    parameter logic [23:0] FULL_CODE = 24'h400020
)
(
    // Clock
    input wire logic clk,
    // Conversions
    output adcc_sample_type raw_sample
);
    initial raw_sample = '0;

    // One conversion after a settling gap; data is scrambled once released
    task automatic send(input logic [23:0] code, input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        raw_sample.valid = 1'b1;
        raw_sample.data = code;
        @(negedge clk);
        raw_sample.valid = 1'b0;
        raw_sample.data = ~code;
    endtask : send

    task automatic apply_zero();
        send(ZERO_CODE, 3);
    endtask : apply_zero

    task automatic apply_full();
        send(FULL_CODE, 0);
    endtask : apply_full
endmodule : adcc_cal_source

// *** test_adcc_cal_ctrl.sv ***
// Self-checking bench of the calibration coefficient block
`timescale 1ns/1ps
module test_adcc_cal_ctrl
    import adcc_pkg::*;
;
    logic clk;
    logic reset;
    logic [3:0] reg_addr;
    logic reg_write;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    adcc_sample_type raw_sample;
    adcc_sample_type result;
    adcc_sample_type result16;
    adcc_status_type status;
    logic [23:0] cur_off;
    logic [23:0] cur_gain;
    int err_total;
    int total_checks;

    adcc_cal_ctrl #(.VARIANT_16BIT(1'b0)) adcc_cal_ctrl_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_sample(raw_sample),
        .result(result), .status(status));
    // Narrow variant shares the bus; only checked before any calibration
    adcc_cal_ctrl #(.VARIANT_16BIT(1'b1)) adcc_cal_ctrl_16_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(), .raw_sample(raw_sample),
        .result(result16), .status());
    adcc_cal_source adcc_cal_source_i (.clk(clk), .raw_sample(raw_sample));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk({16'h0000, reg_rdata}, {16'h0000, exp});
    endtask : rd

    task automatic wr24(input logic [3:0] a, input logic [23:0] v);
        wr(a, v[23:16]);
        wr(a + 4'h1, v[15:8]);
        wr(a + 4'h2, v[7:0]);
        if (a == ADDR_OFFSET_COEF_HIGH)
            cur_off = v;
        else
            cur_gain = v;
    endtask : wr24

    task automatic rd24(input logic [3:0] a, input logic [23:0] exp);
        rd(a, exp[23:16]);
        rd(a + 4'h1, exp[15:8]);
        rd(a + 4'h2, exp[7:0]);
    endtask : rd24

    function automatic logic signed [63:0] clip(input logic signed [63:0] v);
        if (v > 64'sh7FFFFF)
            return 64'sh7FFFFF;
        if (v < -64'sh800000)
            return -64'sh800000;
        return v;
    endfunction : clip

    function automatic logic [23:0] corr(input logic [23:0] x, input bit v16);
        logic signed [63:0] d;
        if (v16)
            d = $signed({{40{x[15]}}, x[15:0], 8'h00});
        else
            d = $signed({{40{x[23]}}, x});
        d = clip(d - $signed({{40{cur_off[23]}}, cur_off}));
        d = clip((d * $signed({40'h0000000000, cur_gain})) >>> 23);
        return d[23:0];
    endfunction : corr

    // Result stands for one cycle, the cycle after the raw pulse ends
    task automatic conv(input logic [23:0] x);
        adcc_cal_source_i.send(x, 0);
        @(negedge clk);
        chk({23'h000000, result.valid}, 24'h000001);
        chk(result.data, corr(x, 1'b0));
        chk(result16.data, corr(x, 1'b1));
    endtask : conv

    task automatic cal_start(input logic [2:0] mode);
        wr(ADDR_SYSTEM_MODE, {5'h00, mode});
        @(negedge clk);
        chk({20'h00000, status}, 24'h000001);
    endtask : cal_start

    task automatic cal_end(input logic [3:0] exp_st);
        for (int i = 0; i < 100 && status.complete !== 1'b1; i++)
            @(negedge clk);
        chk({20'h00000, status}, {20'h00000, exp_st});
        rd(ADDR_SYSTEM_MODE, 8'h00);
    endtask : cal_end

    task automatic clear_status(input logic [7:0] v, input logic [3:0] exp_st);
        wr(ADDR_STATUS, v);
        @(negedge clk);
        chk({20'h00000, status}, {20'h00000, exp_st});
    endtask : clear_status

    initial
    begin
        #(25ns * 4000);
        err_total++;
        summarize();
    end

    initial
    begin
        err_total = 0;
        total_checks = 0;
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
        cur_off = OFFSET_RESET;
        cur_gain = GAIN_RESET;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk({20'h00000, status}, 24'h000000);
        rd24(ADDR_OFFSET_COEF_HIGH, 24'h000000);
        rd24(ADDR_GAIN_COEF_HIGH, 24'h800000);
        wr(4'h9, 8'h5A);
        rd(4'h9, 8'h00);
        conv(24'h012345);
        wr24(ADDR_GAIN_COEF_HIGH, 24'h940000);
        rd24(ADDR_GAIN_COEF_HIGH, 24'h940000);
        wr24(ADDR_OFFSET_COEF_HIGH, 24'hFFFFF0);
        rd24(ADDR_OFFSET_COEF_HIGH, 24'hFFFFF0);
        conv(24'h001000);
        wr24(ADDR_GAIN_COEF_HIGH, 24'h800000);
        wr24(ADDR_OFFSET_COEF_HIGH, 24'h000100);
        conv(24'h000003);
        wr24(ADDR_GAIN_COEF_HIGH, 24'hFFFFFF);
        conv(24'h7FFF00);
        for (int c = 1; c < 8; c++)
        begin
            if (c != 4 && c != 5)
            begin
                wr(ADDR_SYSTEM_MODE, 8'(c));
                @(negedge clk);
                chk({20'h00000, status}, 24'h000000);
            end
        end
        cal_start(MODE_SYS_OFFSET);
        adcc_cal_source_i.apply_zero();
        cal_end(4'h6);
        rd24(ADDR_OFFSET_COEF_HIGH, 24'h000020);
        clear_status(8'h08, 4'h0);
        cal_start(MODE_SYS_GAIN);
        adcc_cal_source_i.apply_full();
        cal_end(4'h6);
        rd24(ADDR_GAIN_COEF_HIGH, 24'((64'h7FFFFF << 23) / 64'h400000));
        clear_status(8'h00, 4'h0);
        for (int k = 0; k < 2; k++)
        begin
            cal_start(MODE_SYS_OFFSET);
            adcc_cal_source_i.send(k == 0 ? OFFSET_NEG_FULL : OFFSET_POS_FULL, 1);
            cal_end(4'hE);
            rd24(ADDR_OFFSET_COEF_HIGH, k == 0 ? OFFSET_NEG_FULL : OFFSET_POS_FULL);
            clear_status(8'h00, 4'h0);
        end
        cal_start(MODE_SYS_GAIN);
        adcc_cal_source_i.send(24'h000000, 1);
        cal_end(4'hE);
        rd24(ADDR_GAIN_COEF_HIGH, 24'hFFFFFF);
        clear_status(8'h00, 4'h0);
        wr24(ADDR_OFFSET_COEF_HIGH, 24'h000000);
        cal_start(MODE_SYS_GAIN);
        adcc_cal_source_i.send(24'h000001, 1);
        cal_end(4'hE);
        rd24(ADDR_GAIN_COEF_HIGH, 24'hFFFFFF);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk({20'h00000, status}, 24'h000000);
        rd24(ADDR_GAIN_COEF_HIGH, 24'h800000);
        summarize();
    end
endmodule : test_adcc_cal_ctrl
